// file: logic/lrp_pma_regs.sv
`default_nettype none
// Functional notes
// - Control bit 14 set suppresses all line transmit output.
// - Amplitude bit 12 applies only while autonegotiation is off.
// - Forced amplitude 1 selects 2.4 V p-p, 0 selects 1.0 V p-p.
// - Control bit 0 loops transmit data back onto receive.
// - Status bit 13, loopback ability, always reads 1.
// - Status bit 12 reports high amplitude ability from a strap.
// - Status bit 11, software power-down ability, reads 1.
// - Status bit 10, energy saving ability, reads 0.
// - Test pattern field 15:13 resets to 000, normal operation.
// - Code 001 sends +1, -1 repeated continuously.
// - Code 010 sends ten +1 then ten -1 symbols repeatedly.
// - Code 011 runs normally as master sending only idle.
// - Reserved bits read 0 and ignore writes.
module lrp_pma_regs
	import lrp_pkg::*;
(
	input wire logic i_clk, // Core clock, 20 MHz.
	input wire logic i_sys_rst, // Asynchronous reset, active high.
	input wire logic i_mdc, // Management clock pin.
	input wire logic i_mdio, // Management data pin, input side.
	output logic o_mdio, // Management data pin, output side.
	output logic o_mdio_oe, // Management data pin driven, high.
	input wire logic [4:0] i_strap_phy_addr, // Port address strap.
	input wire logic i_strap_hi_able, // High amplitude ability strap.
	input wire logic i_strap_hi_dflt, // High amplitude default strap.
	input wire logic i_an_enable, // Autonegotiation enabled.
	input wire logic i_an_hi_amp, // Negotiated high amplitude.
	input wire logic i_sym_tick, // One pulse per line symbol.
	output logic o_tx_disable, // Line transmit output suppressed.
	output logic o_hi_amplitude, // 1 is 2.4 V p-p, 0 is 1.0 V p-p.
	output logic o_energy_saving, // Energy saving enable.
	output logic o_loopback, // Local attachment loopback.
	output logic o_pattern_on, // Test pattern drives the line.
	output logic o_symbol_pos, // Pattern symbol, 1 is +1.
	output logic o_master_idle // Normal idle as master.
);
	logic [2:0] mdc_s_r;
	logic [2:0] mdio_s_r;
	logic mdc_lvl_r;
	logic mdio_lvl_r;
	lrp_mdio_state_t state_r;
	logic [5:0] cnt_r;
	logic [15:0] sh_r;
	logic [15:0] rd_sh_r;
	logic [15:0] addr_r;
	logic [1:0] op_r;
	logic match_r;
	logic [15:0] ctrl_r;
	logic [15:0] test_r;
	logic hi_able_r;
	logic [4:0] phy_addr_r;
	logic strap_done_r;
	wire logic mdc_rise;
	wire logic [15:0] sh_in;
	wire logic reading;
	wire logic frame_end;
	wire logic wr_en;
	wire logic [15:0] stat_word;
	wire logic [15:0] rd_data;
	wire logic hi_amp_nxt;

	// Pins pass three flops; a level counts once the last two agree.
	// Reset to the idle high levels, so that no false rise follows reset.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mdc_s_r <= 3'h7;
			mdio_s_r <= 3'h7;
			mdc_lvl_r <= 1'b1;
			mdio_lvl_r <= 1'b1;
		end else begin
			mdc_s_r <= {mdc_s_r[1:0], i_mdc};
			mdio_s_r <= {mdio_s_r[1:0], i_mdio};
			if (mdc_s_r[1] == mdc_s_r[2])
				mdc_lvl_r <= mdc_s_r[2];
			if (mdio_s_r[1] == mdio_s_r[2])
				mdio_lvl_r <= mdio_s_r[2];
		end
	end

	// Frame decode and register selection.
	assign mdc_rise = mdc_s_r[1] & mdc_s_r[2] & ~mdc_lvl_r;
	assign sh_in = {sh_r[14:0], mdio_lvl_r};
	assign reading = match_r & op_r[1];
	assign frame_end = mdc_rise & (state_r == MD_FRAME) & (cnt_r == FR_LAST);
	assign wr_en = frame_end & match_r & (op_r == OP_WR);
	assign stat_word = STAT_RST | (hi_able_r ? STAT_HI_ABLE : 16'h0000);
	assign rd_data = (addr_r == REG_CTRL_ADDR) ? ctrl_r :
		(addr_r == REG_STAT_ADDR) ? stat_word :
		(addr_r == REG_TEST_ADDR) ? test_r : RD_UNMAPPED;

	// Serial engine: at least 32 ones of preamble, then 32 frame bits.
	// The reply bit is updated just after the filtered rise, giving the host one
	// management clock period, less the filter delay, of setup before its next sample.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= MD_PRE;
			cnt_r <= 6'h00;
			sh_r <= 16'h0000;
			rd_sh_r <= 16'h0000;
			op_r <= OP_ADDR;
			match_r <= 1'b0;
			o_mdio <= 1'b0;
			o_mdio_oe <= 1'b0;
		end else if (mdc_rise && state_r == MD_PRE) begin
			if (mdio_lvl_r)
				cnt_r <= (cnt_r == PRE_MIN) ? cnt_r : cnt_r + 6'h01;
			else if (cnt_r == PRE_MIN) begin
				state_r <= MD_FRAME;
				cnt_r <= 6'h01;
				sh_r <= sh_in;
			end else
				cnt_r <= 6'h00;
		end else if (mdc_rise) begin
			cnt_r <= cnt_r + 6'h01;
			sh_r <= sh_in;
			if (cnt_r == FR_HDR_END) begin
				op_r <= sh_in[11:10];
				match_r <= (sh_in[13:12] == ST_C45) &&
					(sh_in[9:5] == phy_addr_r) && (sh_in[4:0] == MMD_PMA);
				rd_sh_r <= rd_data;
			end
			if (cnt_r == FR_TA1 && reading) begin
				o_mdio_oe <= 1'b1;
				o_mdio <= 1'b0;
			end else if (cnt_r > FR_TA1 && cnt_r < FR_LAST && reading) begin
				o_mdio <= rd_sh_r[15];
				rd_sh_r <= {rd_sh_r[14:0], 1'b0};
			end
			if (cnt_r == FR_LAST) begin
				o_mdio_oe <= 1'b0;
				o_mdio <= 1'b0;
				state_r <= MD_PRE;
				cnt_r <= 6'h00;
				match_r <= 1'b0;
			end
		end
	end

	// Address pointer: set by address frames, stepped by read-increment.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			addr_r <= 16'h0000;
		else if (frame_end && match_r && op_r == OP_ADDR)
			addr_r <= sh_in;
		else if (frame_end && match_r && op_r == OP_RDINC)
			addr_r <= addr_r + 16'h0001;
	end

	// Straps are caught on the first edge after release, never in reset.
	// A forced high amplitude request is dropped when the strap denies ability.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			strap_done_r <= 1'b0;
			hi_able_r <= 1'b0;
			phy_addr_r <= 5'h00;
			ctrl_r <= CTRL_RST;
			test_r <= TEST_RST;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			hi_able_r <= i_strap_hi_able;
			phy_addr_r <= i_strap_phy_addr;
			ctrl_r[BIT_HI_AMP] <= i_strap_hi_dflt & i_strap_hi_able;
		end else if (wr_en && addr_r == REG_CTRL_ADDR) begin
			ctrl_r <= sh_in & CTRL_RW_MASK;
			ctrl_r[BIT_HI_AMP] <= sh_in[BIT_HI_AMP] & hi_able_r;
		end else if (wr_en && addr_r == REG_TEST_ADDR)
			test_r <= sh_in & TEST_RW_MASK;
	end

	// Negotiated amplitude overrides the forced bit while enabled.
	assign hi_amp_nxt = i_an_enable ? i_an_hi_amp : ctrl_r[BIT_HI_AMP];

	// Line controls are registered so the outputs come from flops.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_tx_disable <= 1'b0;
			o_hi_amplitude <= 1'b0;
			o_energy_saving <= 1'b0;
			o_loopback <= 1'b0;
		end else begin
			o_tx_disable <= ctrl_r[BIT_TX_DIS];
			o_hi_amplitude <= hi_amp_nxt;
			o_energy_saving <= ctrl_r[BIT_EEE];
			o_loopback <= ctrl_r[BIT_LOOP];
		end
	end

	lrp_test_pattern u_pattern (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_mode(test_r[TEST_MSB:TEST_LSB]),
		.i_tx_disable(ctrl_r[BIT_TX_DIS]),
		.i_sym_tick(i_sym_tick),
		.o_pattern_on(o_pattern_on),
		.o_symbol_pos(o_symbol_pos),
		.o_master_idle(o_master_idle)
	);

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	tx_disable_out_a: assert property (
		ctrl_r[BIT_TX_DIS] ##1 ctrl_r[BIT_TX_DIS] |-> o_tx_disable)
		else $error("transmit disable not applied");
	forced_amp_a: assert property (
		!i_an_enable |=> o_hi_amplitude == $past(ctrl_r[BIT_HI_AMP]))
		else $error("forced amplitude not applied");
	negotiated_amp_a: assert property (
		i_an_enable |=> o_hi_amplitude == $past(i_an_hi_amp))
		else $error("negotiated amplitude not applied");
	loopback_out_a: assert property (
		$changed(ctrl_r[BIT_LOOP]) |=> o_loopback == $past(ctrl_r[BIT_LOOP]))
		else $error("loopback control not followed");
	ability_bits_a: assert property (
		strap_done_r |-> stat_word[13] && stat_word[11] && !stat_word[10])
		else $error("fixed ability bits wrong");
	hi_able_a: assert property (
		strap_done_r |-> stat_word[BIT_HI_AMP] == hi_able_r &&
		stat_word[9:0] == 10'h000)
		else $error("high amplitude ability bit wrong");
	test_reset_a: assert property (@(posedge i_clk)
		$fell(i_sys_rst) |-> test_r == TEST_RST)
		else $error("test pattern field not reset to normal");
	reserved_zero_a: assert property (
		(ctrl_r & ~CTRL_RW_MASK) == 16'h0000 &&
		(test_r & ~TEST_RW_MASK) == 16'h0000)
		else $error("reserved bit became set");
	read_turn_a: assert property (
		mdc_rise && state_r == MD_FRAME && cnt_r == FR_TA1 && reading
		|=> o_mdio_oe && !o_mdio)
		else $error("read turnaround not driven low");
endmodule : lrp_pma_regs
`default_nettype wire

// file: logic/lrp_pkg.sv
`default_nettype none
package lrp_pkg;
	// Management register addresses inside the attachment MMD.
	localparam logic [15:0] REG_CTRL_ADDR = 16'h08F6;
	localparam logic [15:0] REG_STAT_ADDR = 16'h08F7;
	localparam logic [15:0] REG_TEST_ADDR = 16'h08F8;
	localparam logic [4:0] MMD_PMA = 5'h01;

	// Field positions in the control and test registers.
	localparam int BIT_TX_DIS = 14;
	localparam int BIT_HI_AMP = 12;
	localparam int BIT_EEE = 10;
	localparam int BIT_LOOP = 0;
	localparam int TEST_MSB = 15;
	localparam int TEST_LSB = 13;

	// Reset values and writable masks.
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_RW_MASK = 16'h5C01;
	localparam logic [15:0] STAT_RST = 16'h2800;
	localparam logic [15:0] STAT_HI_ABLE = 16'h1000;
	localparam logic [15:0] TEST_RST = 16'h0000;
	localparam logic [15:0] TEST_RW_MASK = 16'hE000;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;

	// Transmitter test pattern codes.
	localparam logic [2:0] TPAT_NORMAL = 3'h0;
	localparam logic [2:0] TPAT_TOGGLE = 3'h1;
	localparam logic [2:0] TPAT_DROOP = 3'h2;
	localparam logic [2:0] TPAT_IDLE = 3'h3;
	localparam logic [4:0] DROOP_HALF = 5'h0A;
	localparam logic [4:0] DROOP_LAST = 5'h13;

	// Clause 45 management frame layout, counted in bits after preamble.
	localparam logic [5:0] PRE_MIN = 6'h20;
	localparam logic [5:0] FR_HDR_END = 6'h0D;
	localparam logic [5:0] FR_TA1 = 6'h0E;
	localparam logic [5:0] FR_LAST = 6'h1F;
	localparam logic [1:0] ST_C45 = 2'h0;
	localparam logic [1:0] OP_ADDR = 2'h0;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] OP_RDINC = 2'h2;

	typedef enum logic {MD_PRE, MD_FRAME} lrp_mdio_state_t;
endpackage : lrp_pkg
`default_nettype wire

// file: logic/lrp_test_pattern.sv
`default_nettype none
module lrp_test_pattern
	import lrp_pkg::*;
(
	input wire logic i_clk, // Core clock.
	input wire logic i_sys_rst, // Asynchronous reset, active high.
	input wire logic [2:0] i_mode, // Test pattern code.
	input wire logic i_tx_disable, // Line output suppressed.
	input wire logic i_sym_tick, // One pulse per line symbol.
	output logic o_pattern_on, // Test pattern drives the line.
	output logic o_symbol_pos, // Pattern symbol, 1 is +1, 0 is -1.
	output logic o_master_idle // Normal idle as master.
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic droop_r;
	wire logic mode_toggle;
	wire logic mode_droop;
	wire logic mode_idle;

	// Codes 100 to 111 match none of these and so fall back to normal.
	assign mode_toggle = (i_mode == TPAT_TOGGLE);
	assign mode_droop = (i_mode == TPAT_DROOP);
	assign mode_idle = (i_mode == TPAT_IDLE);
	assign cnt_nxt = (cnt_r == DROOP_LAST) ? 5'h00 : cnt_r + 5'h01;

	// Symbols advance only on the line's symbol tick so rates match.
	// A droop run always starts with +1, even when entered from toggle.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= 5'h00;
			droop_r <= 1'b0;
			o_symbol_pos <= 1'b1;
			o_pattern_on <= 1'b0;
			o_master_idle <= 1'b0;
		end else begin
			o_pattern_on <= (mode_toggle | mode_droop) & ~i_tx_disable;
			o_master_idle <= mode_idle & ~i_tx_disable;
			droop_r <= mode_droop;
			if (!mode_droop)
				cnt_r <= 5'h00;
			else if (i_sym_tick)
				cnt_r <= cnt_nxt;
			if (!(mode_toggle | mode_droop) || (mode_droop && !droop_r))
				o_symbol_pos <= 1'b1;
			else if (i_sym_tick && mode_toggle)
				o_symbol_pos <= ~o_symbol_pos;
			else if (i_sym_tick)
				o_symbol_pos <= (cnt_nxt < DROOP_HALF);
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// A droop period ends on a wrap to a +1 run.
	sequence s_droop_wrap;
		mode_droop && i_sym_tick && cnt_r == DROOP_LAST;
	endsequence

	toggle_alternates_a: assert property (
		mode_toggle && i_sym_tick ##1 mode_toggle
		|-> o_symbol_pos != $past(o_symbol_pos))
		else $error("toggle pattern did not alternate");
	droop_fall_a: assert property (
		mode_droop && i_sym_tick && cnt_r == DROOP_HALF - 5'h01
		|=> !o_symbol_pos)
		else $error("droop pattern did not turn to minus one");
	droop_wrap_a: assert property (
		s_droop_wrap |=> o_symbol_pos && cnt_r == 5'h00)
		else $error("droop pattern did not restart with plus one");
	undefined_mode_a: assert property (
		i_mode[2] |=> !o_pattern_on && !o_master_idle)
		else $error("undefined code produced a test pattern");
	disable_quiet_a: assert property (
		i_tx_disable |=> !o_pattern_on && !o_master_idle)
		else $error("pattern drove the line while disabled");
endmodule : lrp_test_pattern
`default_nettype wire

// file: dv/lrp_mdio_host.sv
`default_nettype none
// Management host: drives MDC and MDIO, the shared line has a pull-up.
module lrp_mdio_host
	import lrp_pkg::*;
(
	input wire logic i_clk, // Core clock.
	input wire logic i_dev_mdio, // Device data out.
	input wire logic i_dev_oe, // Device drives the line.
	input wire logic [4:0] i_phy_addr, // Target port address.
	output logic o_mdc, // Management clock, idles high.
	output logic o_mdio, // Resolved line level.
	output logic o_rd_stb, // Read word ready, one clock.
	output logic [15:0] o_rd_data // Read word.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b0;
	logic val = 1'b1;
	// A released line floats to the pull-up level, never to the old value.
	assign o_mdio = i_dev_oe ? i_dev_mdio : (drv ? val : 1'b1);
	initial begin
		o_mdc = 1'b1;
		o_rd_stb = 1'b0;
		o_rd_data = 16'h0000;
	end
	// Six clocks low, six high, so the filter in the device sees every edge.
	task automatic mbit(input logic b, input logic d, output logic s);
		@(posedge i_clk);
		o_mdc <= 1'b0;
		val <= b;
		drv <= d;
		repeat (5) @(posedge i_clk);
		s = o_mdio;
		@(posedge i_clk);
		o_mdc <= 1'b1;
		repeat (5) @(posedge i_clk);
	endtask : mbit
	// Reads release the line from the turnaround on; the gap lets oe drop.
	task automatic frame(input logic [1:0] op, input logic [15:0] v);
		logic [31:0] w;
		logic [15:0] rd;
		logic s;
		w = {ST_C45, op, i_phy_addr, MMD_PMA, 2'b10, v};
		rd = 16'h0000;
		for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, s);
		for (int i = 0; i < 32; i++) begin
			mbit(w[31 - i], !(op[1] && i >= 14), s);
			if (i >= 16) rd[31 - i] = s;
		end
		@(posedge i_clk);
		drv <= 1'b0;
		o_rd_data <= rd;
		o_rd_stb <= op[1];
		@(posedge i_clk);
		o_rd_stb <= 1'b0;
		repeat (12) @(posedge i_clk);
	endtask : frame
endmodule : lrp_mdio_host
`default_nettype wire

// file: dv/long_reach_pma_control_status_test.sv
`default_nettype none
module long_reach_pma_control_status_test
	import lrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mdc, mdio, mdo, moe, ab = 1'b1, df = 1'b1, an = 1'b0, anh = 1'b0;
	logic tick = 1'b0;
	logic txd, hi, eee, lpb, pon, spos, midle, rstb;
	logic [4:0] pa = 5'h00;
	logic [15:0] rdat, v;
	logic [15:0] exp_q[$];
	int bad_count = 0;
	int n_tests = 0;
	integer seed = 32'h6C37F69C;
	always #25 clk = ~clk;
	lrp_pma_regs lrp_pma_regs_inst (.i_clk(clk), .i_sys_rst(rst), .i_mdc(mdc),
		.i_mdio(mdio), .o_mdio(mdo), .o_mdio_oe(moe), .i_strap_phy_addr(pa),
		.i_strap_hi_able(ab), .i_strap_hi_dflt(df), .i_an_enable(an),
		.i_an_hi_amp(anh), .i_sym_tick(tick), .o_tx_disable(txd),
		.o_hi_amplitude(hi), .o_energy_saving(eee), .o_loopback(lpb),
		.o_pattern_on(pon), .o_symbol_pos(spos), .o_master_idle(midle));
	lrp_mdio_host lrp_mdio_host_inst (.i_clk(clk), .i_dev_mdio(mdo),
		.i_dev_oe(moe), .i_phy_addr(pa), .o_mdc(mdc), .o_mdio(mdio),
		.o_rd_stb(rstb), .o_rd_data(rdat));
	task automatic chk(input logic [15:0] got, input logic [15:0] ex);
		n_tests++;
		if (got !== ex) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask : chk
	task automatic test_done();
		// A queued read that never came back is a mismatch as well.
		chk(16'(exp_q.size()), 16'h0000);
		$display("checks=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		lrp_mdio_host_inst.frame(OP_ADDR, a);
		lrp_mdio_host_inst.frame(OP_WR, d);
	endtask : wr
	// The expected word is queued before the read frame goes out.
	task automatic rd(input logic [15:0] a, input logic [15:0] ex);
		lrp_mdio_host_inst.frame(OP_ADDR, a);
		exp_q.push_back(ex);
		lrp_mdio_host_inst.frame(2'h3, 16'h0000);
	endtask : rd
	// Line outputs are looked at on the falling edge, after updates land.
	task automatic line(input logic [5:0] ex);
		@(negedge clk);
		chk({10'h000, txd, hi, eee, lpb, pon, midle}, {10'h000, ex});
	endtask : line
	task automatic pulse();
		@(posedge clk) tick <= 1'b1;
		@(posedge clk) tick <= 1'b0;
		@(negedge clk);
	endtask : pulse
	task automatic boot(input logic a, input logic d);
		@(posedge clk);
		rst <= 1'b1;
		ab <= a;
		df <= d;
		pa <= 5'($random(seed));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		line({1'b0, a & d, 4'h0});
		rd(REG_CTRL_ADDR, CTRL_RST | {3'h0, a & d, 12'h000});
		rd(REG_STAT_ADDR, STAT_RST | (a ? STAT_HI_ABLE : 16'h0000));
		rd(REG_TEST_ADDR, TEST_RST);
		$display("test reset done");
	endtask : boot
	// Every read word is compared with the oldest queued note; a read with none queued counts as a mismatch.
	always @(posedge clk) begin
		if (rstb === 1'b1) begin
			if (exp_q.size() == 0) chk(rdat, ~rdat);
			else chk(rdat, exp_q.pop_front());
		end
	end
	initial begin
		repeat (95000) @(posedge clk);
		chk(16'h0000, 16'h0001);
		test_done();
	end
	initial begin
		boot(1'b1, 1'b1);
		v = 16'($random(seed));
		wr(REG_CTRL_ADDR, v);
		rd(REG_CTRL_ADDR, v & CTRL_RW_MASK);
		line({v[14], v[12], v[10], v[0], 2'h0});
		wr(REG_CTRL_ADDR, 16'hFFFF);
		line(6'h3C);
		@(posedge clk) an <= 1'b1;
		repeat (3) @(posedge clk);
		line(6'h2C);
		@(posedge clk) anh <= 1'b1;
		repeat (3) @(posedge clk);
		line(6'h3C);
		@(posedge clk) an <= 1'b0;
		wr(REG_STAT_ADDR, 16'h0000);
		rd(REG_STAT_ADDR, STAT_RST | STAT_HI_ABLE);
		rd(16'h0123, RD_UNMAPPED);
		lrp_mdio_host_inst.frame(OP_ADDR, REG_CTRL_ADDR);
		exp_q.push_back(16'h5C01);
		lrp_mdio_host_inst.frame(OP_RDINC, 16'h0000);
		exp_q.push_back(STAT_RST | STAT_HI_ABLE);
		lrp_mdio_host_inst.frame(2'h3, 16'h0000);
		wr(REG_CTRL_ADDR, 16'h0000);
		line(6'h00);
		$display("test control done");
		for (int c = 0; c < 8; c++) begin
			wr(REG_TEST_ADDR, {3'(c), 13'h1FFF});
			rd(REG_TEST_ADDR, {3'(c), 13'h0000});
			line({4'h0, c == 1 || c == 2, c == 3});
			if (c == 1) begin
				v[0] = spos;
				repeat (4) begin
					pulse();
					v[0] = ~v[0];
					chk({15'h0000, spos}, {15'h0000, v[0]});
				end
			end
			if (c == 2) begin
				chk({15'h0000, spos}, 16'h0001);
				for (int k = 1; k < 26; k++) begin
					pulse();
					chk({15'h0000, spos}, {15'h0000, (k % 20) < 10});
				end
			end
		end
		$display("test patterns done");
		wr(REG_TEST_ADDR, 16'h2000);
		wr(REG_CTRL_ADDR, 16'h4000);
		line(6'h20);
		wr(REG_CTRL_ADDR, 16'h0000);
		line(6'h02);
		wr(REG_TEST_ADDR, 16'h0000);
		line(6'h00);
		$display("test disable done");
		boot(1'b0, 1'b1);
		wr(REG_CTRL_ADDR, 16'hFFFF);
		rd(REG_CTRL_ADDR, 16'h4C01);
		repeat (5) @(posedge clk);
		$display("test no_high_ability done");
		test_done();
	end
endmodule : long_reach_pma_control_status_test
`default_nettype wire
